// ### rtl/touch_i2c_pkg.sv
// Shared constants for the touch converter two-wire command link.
// Assumes both ends run on clock_i at 50 MHz and are joined by touch_i2c_if.
`default_nettype none

package touch_i2c_pkg;

  // ****************************************************************
  // Address byte
  // ****************************************************************
  localparam logic [4:0] ADDR_PREFIX = 5'h12;
  localparam int ADDR_RW_BIT = 0;

  // ****************************************************************
  // Command byte layout: channel[7:4] power[3:2] mode[1] unused[0]
  // ****************************************************************
  localparam int CMD_CHAN_LSB = 4;
  localparam int CMD_PWR_UPPER_BIT = 3;
  localparam int CMD_PWR_LOWER_BIT = 2;
  localparam int CMD_MODE_BIT = 1;

  // ****************************************************************
  // Bit positions inside a nine-clock byte frame
  // ****************************************************************
  localparam logic [3:0] BIT_CHAN_LAST = 4'h3;
  localparam logic [3:0] BIT_ACQ = 4'h4;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // ****************************************************************
  // Converter input select codes
  // ****************************************************************
  localparam logic [3:0] MUX_NONE = 4'h0;
  localparam logic [3:0] MUX_TEMP_A = 4'h1;
  localparam logic [3:0] MUX_BAT_A = 4'h2;
  localparam logic [3:0] MUX_AUX_A = 4'h3;
  localparam logic [3:0] MUX_TEMP_B = 4'h4;
  localparam logic [3:0] MUX_BAT_B = 4'h5;
  localparam logic [3:0] MUX_AUX_B = 4'h6;
  localparam logic [3:0] MUX_YP = 4'h7;
  localparam logic [3:0] MUX_XP = 4'h8;
  localparam logic [3:0] MUX_YN = 4'h9;

  // Panel driver enables {y_minus, y_plus, x_minus, x_plus}
  localparam logic [3:0] DRV_OFF = 4'h0;
  localparam logic [3:0] DRV_X = 4'h3;
  localparam logic [3:0] DRV_Y = 4'hc;
  localparam logic [3:0] DRV_XN_YP = 4'h6;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic REF_RESET = 1'b0;
  localparam logic ADC_RESET = 1'b0;
  localparam logic IRQ_EN_RESET = 1'b1;
  localparam logic [1:0] PWR_RESET = 2'h0;

  // ****************************************************************
  // Host register map and serial timing
  // ****************************************************************
  localparam logic [2:0] HREG_TARGET = 3'h0;
  localparam logic [2:0] HREG_COMMAND = 3'h1;
  localparam logic [2:0] HREG_READ = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_RESULT = 3'h4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 320;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYCLES - 1);

endpackage

`default_nettype wire

// ### rtl/touch_i2c_if.sv
// Open-drain two-wire link between the host master and the converter slave.
// Assumes pull-ups: a line is low only while some end enables its low drive.
`default_nettype none

interface touch_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Wired-AND resolution of both lines
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface

`default_nettype wire

// ### rtl/touch_adc_i2c_command_slave.sv
// Slave end of the touch converter link: address match, command decode,
// acquisition and conversion sequencing, result read-out.
// Assumes the link lines are asynchronous to clock_i and the converter
// core reports end of conversion with conv_done_i on clock_i.
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none

module touch_adc_i2c_command_slave
  import touch_i2c_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link
  touch_i2c_if.device bus,
  // Straps and converter core
  input wire logic [1:0] address_strap_pins_i,
  input wire logic [11:0] result_i,
  input wire logic conv_done_i,
  // Analog control
  output logic [3:0] mux_select_o,
  output logic mux_connect_o,
  output logic [3:0] panel_drive_o,
  output logic acquire_o,
  output logic convert_start_o,
  output logic converting_o,
  output logic eight_bit_mode_o,
  output logic ref_power_o,
  output logic adc_power_o,
  output logic pen_irq_enable_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_IGNORE, ST_TX, ST_DONE} dev_state_t;

  // ****************************************************************
  // Decode tables
  // ****************************************************************
  function automatic logic [3:0] decode_mux(input logic [3:0] code);
    logic [3:0] sel;
    sel = MUX_NONE;
    unique case (code)
      4'h0: sel = MUX_TEMP_A;
      4'h1: sel = MUX_BAT_A;
      4'h2: sel = MUX_AUX_A;
      4'h4: sel = MUX_TEMP_B;
      4'h5: sel = MUX_BAT_B;
      4'h6: sel = MUX_AUX_B;
      4'hc: sel = MUX_YP;
      4'hd: sel = MUX_XP;
      4'he: sel = MUX_XP;
      4'hf: sel = MUX_YN;
      default: sel = MUX_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic [3:0] decode_drv(input logic [3:0] code);
    logic [3:0] drv;
    drv = DRV_OFF;
    unique case (code)
      4'h8: drv = DRV_X;
      4'h9: drv = DRV_Y;
      4'ha: drv = DRV_XN_YP;
      4'hc: drv = DRV_X;
      4'hd: drv = DRV_Y;
      4'he: drv = DRV_XN_YP;
      4'hf: drv = DRV_XN_YP;
      default: drv = DRV_OFF;
    endcase
    return drv;
  endfunction

  // ****************************************************************
  // Input synchronisers and bus condition detection
  // ****************************************************************
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [1:0] strap_s1_q, strap_s2_q;

  // Two stages per input, a third for edge detection
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {bus.scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {bus.sda, sda_s1_q, sda_s2_q};
      strap_s1_q <= address_strap_pins_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  wire scl_rise = scl_s2_q && !scl_s3_q;
  wire scl_fall = !scl_s2_q && scl_s3_q;
  wire scl_high = scl_s2_q && scl_s3_q;
  wire start_det = scl_high && sda_s3_q && !sda_s2_q;
  wire stop_det = scl_high && !sda_s3_q && sda_s2_q;

  // ****************************************************************
  // Byte framing state machine
  // ****************************************************************
  dev_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [11:0] res_q;
  logic lo_next_q;
  logic sda_low_q;

  wire active = (state_q != ST_IDLE) && (state_q != ST_DONE);
  wire addr_hit = (rx_q[7:3] == ADDR_PREFIX)
    && (rx_q[2:1] == strap_s2_q);
  wire read_req = rx_q[ADDR_RW_BIT];
  wire [7:0] tx_next = lo_next_q ? {res_q[3:0], 4'h0} : res_q[11:4];
  wire tx_bit_phase = (bit_cnt_q != 4'h0) && (bit_cnt_q < BIT_ACK);

  // Bits are sampled on rising SCL, SDA changes only after falling SCL
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      res_q <= 12'h000;
      lo_next_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (scl_rise && active) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q < BIT_ACK) begin
        rx_q <= {rx_q[6:0], sda_s2_q};
      end
      if (state_q == ST_TX && bit_cnt_q == BIT_ACK && sda_s2_q) begin
        state_q <= ST_DONE; // Master ended the read
      end
    end else if (scl_fall && active) begin
      if (bit_cnt_q == BIT_ACK) begin
        unique case (state_q)
          ST_ADDR: begin
            sda_low_q <= addr_hit;
            if (!addr_hit) begin
              state_q <= ST_DONE;
            end
          end
          ST_CMD: sda_low_q <= 1'b1;
          default: sda_low_q <= 1'b0;
        endcase
      end else if (bit_cnt_q == BIT_END) begin
        bit_cnt_q <= 4'h0;
        sda_low_q <= 1'b0;
        if (state_q == ST_ADDR && read_req) begin
          state_q <= ST_TX;
          res_q <= result_i;
          tx_q <= result_i[11:4];
          sda_low_q <= !result_i[11];
          lo_next_q <= 1'b1;
        end else if (state_q == ST_ADDR) begin
          state_q <= ST_CMD;
        end else if (state_q == ST_CMD) begin
          state_q <= ST_IGNORE;
        end else if (state_q == ST_TX) begin
          tx_q <= tx_next;
          sda_low_q <= !tx_next[7];
          lo_next_q <= !lo_next_q;
        end
      end else if (state_q == ST_TX && tx_bit_phase) begin
        tx_q <= {tx_q[6:0], 1'b0};
        sda_low_q <= !tx_q[6];
      end
    end
  end

  // Open-drain data: only ever pulled low
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_low_q;

  // ****************************************************************
  // Command decode and conversion sequencing
  // ****************************************************************
  logic [3:0] chan_q;
  logic [1:0] pwr_q;
  logic cmd_full_q;

  wire in_cmd = (state_q == ST_CMD);
  wire [3:0] chan_now = {rx_q[2:0], sda_s2_q};
  wire chan_taken = in_cmd && scl_rise && (bit_cnt_q == BIT_CHAN_LAST);
  wire acq_begin = in_cmd && scl_fall && (bit_cnt_q == BIT_ACQ);
  wire cmd_taken = in_cmd && scl_fall && (bit_cnt_q == BIT_ACK);
  wire cmd_end = (start_det || stop_det) && (in_cmd || state_q == ST_IGNORE);
  wire pos_meas = chan_q[3] && chan_q[2];
  wire conv_end = conv_done_i && converting_o;

  // Channel, multiplexer and power sequencing
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      chan_q <= 4'h0;
      pwr_q <= PWR_RESET;
      cmd_full_q <= 1'b0;
      mux_select_o <= MUX_NONE;
      mux_connect_o <= 1'b0;
      panel_drive_o <= DRV_OFF;
      acquire_o <= 1'b0;
      convert_start_o <= 1'b0;
      converting_o <= 1'b0;
      eight_bit_mode_o <= 1'b0;
      ref_power_o <= REF_RESET;
      adc_power_o <= ADC_RESET;
      pen_irq_enable_o <= IRQ_EN_RESET;
    end else begin
      convert_start_o <= 1'b0;
      if (chan_taken) begin
        chan_q <= chan_now;
        mux_select_o <= decode_mux(chan_now);
        mux_connect_o <= (decode_mux(chan_now) != MUX_NONE);
      end
      if (acq_begin) begin
        acquire_o <= 1'b1;
        panel_drive_o <= decode_drv(chan_q);
        pen_irq_enable_o <= 1'b0;
      end
      if (cmd_taken) begin
        cmd_full_q <= 1'b1;
        pwr_q <= {rx_q[CMD_PWR_UPPER_BIT], rx_q[CMD_PWR_LOWER_BIT]};
        eight_bit_mode_o <= rx_q[CMD_MODE_BIT];
      end
      if (cmd_end) begin
        cmd_full_q <= 1'b0;
        acquire_o <= 1'b0;
        mux_connect_o <= 1'b0;
        if (cmd_full_q) begin
          ref_power_o <= pwr_q[1];
        end
        if (acquire_o && cmd_full_q) begin
          convert_start_o <= 1'b1;
          converting_o <= 1'b1;
          adc_power_o <= 1'b1;
          if (!pos_meas) begin
            panel_drive_o <= DRV_OFF;
          end
        end else begin
          panel_drive_o <= DRV_OFF;
        end
      end
      if (conv_end) begin
        converting_o <= 1'b0;
        adc_power_o <= pwr_q[0];
        pen_irq_enable_o <= !pwr_q[0];
        if (!pwr_q[0]) begin
          panel_drive_o <= DRV_OFF;
        end
      end
    end
  end

endmodule // touch_adc_i2c_command_slave

`default_nettype wire

// ### rtl/touch_i2c_host_master.sv
// Master end of the touch converter link with a small software register port.
// Assumes software strobes are on clock_i; the slave never stretches SCL.
`default_nettype none

module touch_i2c_host_master
  import touch_i2c_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link
  touch_i2c_if.host bus,
  // Software register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [15:0] rdata_o
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

  // ****************************************************************
  // Registers and link sampling
  // ****************************************************************
  host_state_t state_q;
  logic [1:0] target_q;
  logic [7:0] cmd_q;
  logic [11:0] result_q;
  logic nack_q;
  logic sda_s1_q, sda_s2_q;
  logic [3:0] qcnt_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic rd_q;
  logic [7:0] shift_q;
  logic scl_low_q, sda_low_q;

  wire idle = (state_q == H_IDLE);
  wire go_write = write_i && addr_i == HREG_COMMAND && idle;
  wire go_read = write_i && addr_i == HREG_READ && idle;
  wire nack_clr = write_i && addr_i == HREG_STATUS && wdata_i[1];
  wire tick = (qcnt_q == QTR_LAST);
  wire tx_frame = (byte_q == 2'h0) || !rd_q;
  wire last_byte = rd_q ? (byte_q == 2'h2) : (byte_q == 2'h1);
  wire [7:0] addr_byte = {ADDR_PREFIX, target_q, rd_q};
  wire bit_val = (bit_q < BIT_ACK) ? (!tx_frame || shift_q[7]) : (tx_frame || last_byte);
  wire frame_end = (bit_q == BIT_ACK);
  wire addr_nack = frame_end && tx_frame && sda_s2_q;

  // Software registers; a missed acknowledge wins over its clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      target_q <= 2'h0;
      cmd_q <= 8'h00;
      nack_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      if (write_i && addr_i == HREG_TARGET) begin
        target_q <= wdata_i[1:0];
      end
      if (go_write) begin
        cmd_q <= wdata_i;
      end
      nack_q <= (state_q == H_BIT && tick && phase_q == 2'h3 && addr_nack) || (nack_q && !nack_clr);
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Read data appear in the cycle after the strobe only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (!read_i) begin
      rdata_o <= 16'h0000;
    end else begin
      unique case (addr_i)
        HREG_TARGET: rdata_o <= {14'h0000, target_q};
        HREG_COMMAND: rdata_o <= {8'h00, cmd_q};
        HREG_STATUS: rdata_o <= {14'h0000, nack_q, !idle};
        HREG_RESULT: rdata_o <= {4'h0, result_q};
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Serial engine: four quarter phases per bit
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= H_IDLE;
      qcnt_q <= 4'h0;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      shift_q <= 8'h00;
      result_q <= 12'h000;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (idle) begin
      qcnt_q <= 4'h0;
      if (go_write || go_read) begin
        state_q <= H_START;
        rd_q <= go_read;
        sda_low_q <= 1'b1; // Start: data falls while clock high
      end
    end else begin
      qcnt_q <= tick ? 4'h0 : qcnt_q + 4'h1;
      if (tick && state_q == H_START) begin
        state_q <= H_BIT;
        phase_q <= 2'h0;
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        shift_q <= addr_byte;
      end else if (tick) begin
        phase_q <= phase_q + 2'h1;
        unique case (phase_q)
          2'h0: scl_low_q <= 1'b1;
          2'h1: sda_low_q <= (state_q == H_STOP) || !bit_val;
          2'h2: scl_low_q <= 1'b0;
          2'h3: begin
            if (state_q == H_STOP) begin
              sda_low_q <= 1'b0; // Stop: data rises while clock high
              state_q <= H_IDLE;
            end else if (!frame_end) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              byte_q <= byte_q + 2'h1;
              shift_q <= cmd_q;
              if (byte_q == 2'h1 && rd_q) begin
                result_q[11:4] <= shift_q;
              end
              if (byte_q == 2'h2) begin
                result_q[3:0] <= shift_q[7:4];
              end
              if (last_byte || addr_nack) begin
                state_q <= H_STOP;
              end
            end
          end
        endcase
      end
    end
  end

  // Open-drain lines: only ever pulled low
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = scl_low_q;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_low_q;

endmodule // touch_i2c_host_master

`default_nettype wire

// ### verif/touch_link_assertions.sv
// Checker for the converter link and the converter control outputs.
// Assumes tb instantiates it beside the link and feeds it by name.
`default_nettype none

module touch_link_checker
  import touch_i2c_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Resolved link lines and slave drive
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_s_oe_i,
  // Converter control
  input wire logic acquire_i,
  input wire logic convert_start_i,
  input wire logic converting_i,
  input wire logic mux_connect_i,
  input wire logic [3:0] mux_select_i,
  input wire logic [3:0] panel_drive_i,
  input wire logic ref_power_i,
  input wire logic adc_power_i
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_slave_sda_stable: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_s_oe_i))
    else $error("slave moved SDA while SCL high");
  a_start_pulse_one: assert property (
    convert_start_i |=> !convert_start_i) else $error("conversion start not one cycle");
  a_conv_disconnects: assert property (
    convert_start_i |-> converting_i && !acquire_i && !mux_connect_i)
    else $error("conversion start with input still connected");
  a_stop_starts_conv: assert property (
    acquire_i && scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] convert_start_i)
    else $error("no conversion after stop");
  a_single_drv_off: assert property (
    acquire_i && mux_select_i inside {[MUX_TEMP_A:MUX_AUX_B]} |-> panel_drive_i == DRV_OFF)
    else $error("drivers on for single-ended input");
  a_pos_x_drivers: assert property (
    acquire_i && mux_select_i == MUX_YP |-> panel_drive_i == DRV_X)
    else $error("wrong drivers for X position");
  a_connect_needs_input: assert property (
    $rose(mux_connect_i) |-> mux_select_i != MUX_NONE) else $error("connected with no input");
  a_ref_at_end: assert property (
    $changed(ref_power_i) |-> convert_start_i) else $error("reference changed mid-command");
  a_adc_at_edges: assert property (
    $changed(adc_power_i) |-> convert_start_i || $fell(converting_i))
    else $error("converter power changed early");

  // Main scenarios reached
  c_conv: cover property (convert_start_i);
  c_done: cover property ($fell(converting_i));
  c_ack: cover property (sda_s_oe_i && scl_i);
  c_drive: cover property (acquire_i && panel_drive_i != DRV_OFF);
endmodule // touch_link_checker

`default_nettype wire

// ### verif/tb.sv
// Testbench: host master and converter slave joined by one link.
// Assumes the package, the interface and both ends are compiled first.
`default_nettype none

module tb import touch_i2c_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock_i, rst_i, write, read, conv_done, mux_conn, acq, cstart, conving;
  logic eight, refp, adcp, irqen;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [15:0] rdata, v;
  logic [1:0] strap, ev;
  logic [11:0] result;
  logic [3:0] mux_sel, drive;
  int fails, cmp_count;
  int acq_count, acq_mark;

  touch_i2c_if link();
  touch_adc_i2c_command_slave touch_adc_i2c_command_slave_inst (.clock_i(clock_i),
    .rst_i(rst_i), .bus(link), .address_strap_pins_i(strap), .result_i(result),
    .conv_done_i(conv_done), .mux_select_o(mux_sel), .mux_connect_o(mux_conn),
    .panel_drive_o(drive), .acquire_o(acq), .convert_start_o(cstart), .converting_o(conving),
    .eight_bit_mode_o(eight), .ref_power_o(refp), .adc_power_o(adcp), .pen_irq_enable_o(irqen));
  touch_i2c_host_master touch_i2c_host_master_inst (.clock_i(clock_i), .rst_i(rst_i),
    .bus(link), .addr_i(addr), .wdata_i(wdata), .write_i(write), .read_i(read), .rdata_o(rdata));
  touch_link_checker touch_link_checker_inst (.clock_i(clock_i), .rst_i(rst_i),
    .scl_i(link.scl), .sda_i(link.sda), .sda_s_oe_i(link.sda_s_oe), .acquire_i(acq),
    .convert_start_i(cstart), .converting_i(conving), .mux_connect_i(mux_conn),
    .mux_select_i(mux_sel), .panel_drive_i(drive), .ref_power_i(refp), .adc_power_i(adcp));

  assign ev = {cstart, acq};

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Counts cycles with acquisition active
  always @(posedge clock_i) if (acq) acq_count <= acq_count + 1;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock_i);
    write <= 1'b0;
  endtask

  task rd(input logic [2:0] a, output logic [15:0] q);
    @(posedge clock_i);
    addr <= a;
    read <= 1'b1;
    @(posedge clock_i);
    read <= 1'b0;
    #1 q = rdata;
  endtask

  // Waits for acquire (0), conversion start (1) or host idle (2)
  task wait_on(input int k);
    int n;
    for (n = 0; n < 3000; n++) begin
      if (k == 2) rd(HREG_STATUS, v);
      else begin
        @(posedge clock_i);
        #1;
      end
      if (k == 2 ? !v[0] : ev[k]) break;
    end
    if (n == 3000) begin
      fails++;
      $display("BAD wait %0d expected done seen hang", k);
      stop_test();
    end
  endtask

  function logic [3:0] exp_mux(input logic [3:0] c);
    case (c)
      4'h0: return MUX_TEMP_A;
      4'h1: return MUX_BAT_A;
      4'h2: return MUX_AUX_A;
      4'h4: return MUX_TEMP_B;
      4'h5: return MUX_BAT_B;
      4'h6: return MUX_AUX_B;
      4'hc: return MUX_YP;
      4'hd, 4'he: return MUX_XP;
      4'hf: return MUX_YN;
      default: return MUX_NONE;
    endcase
  endfunction

  function logic [3:0] exp_drv(input logic [3:0] c);
    case (c)
      4'h8, 4'hc: return DRV_X;
      4'h9, 4'hd: return DRV_Y;
      4'ha, 4'he, 4'hf: return DRV_XN_YP;
      default: return DRV_OFF;
    endcase
  endfunction

  // One write cycle followed by its conversion
  task cmd_test(input logic [7:0] c);
    wr(HREG_COMMAND, c);
    wait_on(0);
    check("mux", 16'(mux_sel), 16'(exp_mux(c[7:4])));
    check("drive", 16'(drive), 16'(exp_drv(c[7:4])));
    check("aconn", 16'(mux_conn), 16'(exp_mux(c[7:4]) != MUX_NONE));
    wait_on(1);
    check("ref", 16'(refp), 16'(c[3]));
    check("adc", 16'(adcp), 16'h1);
    check("conn", 16'(mux_conn), 16'h0);
    check("cdrv", 16'(drive), c[7:6] == 2'h3 ? 16'(exp_drv(c[7:4])) : 16'h0);
    @(posedge clock_i) conv_done <= 1'b1;
    @(posedge clock_i) conv_done <= 1'b0;
    @(posedge clock_i);
    #1;
    check("conv", 16'(conving), 16'h0);
    check("adc2", 16'(adcp), 16'(c[2]));
    check("irq", 16'(irqen), 16'(!c[2]));
    check("mode", 16'(eight), 16'(c[1]));
    if (!c[2]) check("off", 16'(drive), 16'h0);
    else check("keep", 16'(drive), c[7:6] == 2'h3 ? 16'(exp_drv(c[7:4])) : 16'h0);
    wait_on(2);
    check("nack", v, 16'h0);
    check("idle", 16'({link.scl, link.sda}), 16'h3);
    rd(HREG_COMMAND, v);
    check("cmdreg", v, 16'(c));
    $display("test command %h done", c);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(33653));
    {rst_i, write, read, conv_done, addr, wdata, result} = '0;
    rst_i = 1'b1;
    strap = 2'($urandom);
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    wr(HREG_TARGET, 8'(strap));
    cmd_test(8'h00);
    for (int c = 0; c < 16; c++) cmd_test({4'(c), 4'($urandom)});
    // Wrong strap bits draw no acknowledge and no acquisition
    acq_mark = acq_count;
    wr(HREG_TARGET, 8'(~strap));
    wr(HREG_COMMAND, 8'hc0);
    wait_on(2);
    check("miss", v, 16'h2);
    check("noacq", 16'(acq_count - acq_mark), 16'h0);
    wr(HREG_STATUS, 8'h02);
    $display("test address miss done");
    // Read cycles with random strap and result
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      strap <= 2'($urandom);
      result <= 12'($urandom);
      repeat (4) @(posedge clock_i);
      wr(HREG_TARGET, 8'(strap));
      rd(HREG_TARGET, v);
      check("target", v, 16'(strap));
      wr(HREG_READ, 8'h00);
      wait_on(2);
      check("rnack", v, 16'h0);
      rd(HREG_RESULT, v);
      check("result", v, 16'(result));
      $display("test read %0d done", i);
    end
    stop_test();
  end
endmodule // tb

`default_nettype wire
